/* hdr_bit_rx.sv */
// HDLC bit destuffing, flag, abort and idle detection
`timescale 1ns/10ps
`include "hdr_defines.svh"
module hdr_bit_rx (
	input  wire logic clk,        // System clock
	input  wire logic rst_b,      // Sync reset, active low
	input  wire logic bit_en,     // One line bit this cycle
	input  wire logic bit_in,     // Line bit value
	output logic      out_valid,  // Destuffed data bit pulse
	output logic      out_bit,    // Destuffed data bit
	output logic      flag_seen,  // Flag pulse
	output logic      abort_seen, // Seventh one pulse
	output logic      idle_seen   // Fifteenth one pulse
);
	logic [3:0] ones;
	logic [6:0] pend;
	logic [2:0] pcnt;
	logic       push;
	logic       push_bit;

	// Bits held back seven places so flag bits never leak out as data
	always_comb begin
		push     = 1'b0;
		push_bit = bit_in;
		if (bit_en) begin
			if (bit_in)
				push = (ones < `HDR_FLAG_ONES);
			else
				push = (ones != `HDR_STUFF_ONES) && (ones != `HDR_FLAG_ONES);
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			ones       <= 4'h0;
			pend       <= 7'h00;
			pcnt       <= 3'h0;
			out_valid  <= 1'b0;
			out_bit    <= 1'b0;
			flag_seen  <= 1'b0;
			abort_seen <= 1'b0;
			idle_seen  <= 1'b0;
		end else begin
			out_valid  <= 1'b0;
			flag_seen  <= bit_en && !bit_in && (ones == `HDR_FLAG_ONES);
			abort_seen <= bit_en && bit_in && (ones == `HDR_FLAG_ONES);
			idle_seen  <= bit_en && bit_in && (ones == `HDR_IDLE_ONES);
			if (bit_en) begin
				if (bit_in && ones != 4'hF)
					ones <= ones + 4'h1;
				else if (!bit_in)
					ones <= 4'h0;
				if (bit_in ? (ones >= `HDR_FLAG_ONES) : (ones == `HDR_FLAG_ONES)) begin
					pend <= 7'h00;
					pcnt <= 3'h0;
				end else if (push) begin
					pend <= {pend[5:0], push_bit};
					if (pcnt == 3'h7) begin
						out_valid <= 1'b1;
						out_bit   <= pend[6];
					end else begin
						pcnt <= pcnt + 3'h1;
					end
				end
			end
		end
	end
endmodule : hdr_bit_rx

/* hdr_crc.sv */
// Bit serial reflected CRC-16 or CRC-32 with good-residue check
`timescale 1ns/10ps
`include "hdr_defines.svh"
module hdr_crc (
	input  wire logic clk,    // System clock
	input  wire logic rst_b,  // Sync reset, active low
	input  wire logic init,   // Restart the CRC
	input  wire logic crc32,  // 1 selects CRC-32
	input  wire logic bit_en, // Data bit this cycle
	input  wire logic bit_in, // Data bit, first sent first
	output logic      crc_ok  // Residue matches
);
	logic [31:0] crc;
	logic [31:0] poly;

	assign poly   = crc32 ? `HDR_POLY32 : `HDR_POLY16;
	assign crc_ok = crc32 ? (crc == `HDR_GOOD32) : (crc[15:0] == `HDR_GOOD16);

	always_ff @(posedge clk) begin
		if (!rst_b)
			crc <= `HDR_INIT32;
		else if (init)
			crc <= crc32 ? `HDR_INIT32 : `HDR_INIT16;
		else if (bit_en)
			crc <= {1'b0, crc[31:1]} ^ ((crc[0] ^ bit_in) ? poly : 32'h00000000);
	end
endmodule : hdr_crc

/* hdr_defines.svh */
// Offsets, field positions, reset values and constants of the receive status block
`ifndef HDR_DEFINES_SVH
`define HDR_DEFINES_SVH
`define HDR_AW         8
`define HDR_OFF_CTRL   8'h00
`define HDR_OFF_BUFPTR 8'h04
`define HDR_OFF_DESCA  8'h08
`define HDR_OFF_DSTAT  8'h0C
`define HDR_OFF_EVST   8'h10
`define HDR_OFF_EVMASK 8'h14
`define HDR_CTRL_RST   32'h00000000
`define HDR_PTR_RST    32'h00000000
`define HDR_MASK_RST   2'h0
`define HDR_CTRL_EN    0
`define HDR_CTRL_C32   1
`define HDR_EV_RXF     0
`define HDR_EV_IDLE    1
`define HDR_FLD_NO     11
`define HDR_FLD_AB     12
`define HDR_FLD_CR     13
`define HDR_FLD_LEN    16
`define HDR_STUFF_ONES 4'h5
`define HDR_FLAG_ONES  4'h6
`define HDR_IDLE_ONES  4'hE
`define HDR_POLY16     32'h00008408
`define HDR_POLY32     32'hEDB88320
`define HDR_INIT16     32'h0000FFFF
`define HDR_INIT32     32'hFFFFFFFF
`define HDR_GOOD16     16'hF0B8
`define HDR_GOOD32     32'hDEBB20E3
`define HDR_RESP_OK    2'h0
`define HDR_RESP_ERR   2'h2
`endif

/* hdr_mem_model.sv */
// Memory model taking data, residual and descriptor writes
`timescale 1ns/10ps
module hdr_mem_model (
	input  wire logic        clk,   // System clock
	input  wire logic        rst_b, // Sync reset, active low
	input  wire logic        req,   // Write request
	input  wire logic [31:0] addr,  // Write address
	input  wire logic [31:0] wdata, // Write data
	input  wire logic [3:0]  be,    // Byte enables
	output logic             ack    // Write taken
);
	logic [31:0] wa [0:63];
	logic [31:0] wd [0:63];
	logic [3:0]  wb [0:63];
	int          n;
	int          dly;
	// Prompt and slow answers alternate
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			ack <= 1'b0;
			n   <= 0;
			dly <= 0;
		end else if (req && ack) begin
			wa[n % 64] <= addr;
			wd[n % 64] <= wdata;
			wb[n % 64] <= be;
			n   <= n + 1;
			ack <= 1'b0;
			dly <= 0;
		end else if (req) begin
			ack <= (dly >= (n % 2) * 2);
			dly <= dly + 1;
		end else begin
			ack <= 1'b0;
		end
	end
endmodule : hdr_mem_model

/* hdr_pkg.sv */
// Types shared by the receive status block
package hdr_pkg;
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_DATA = 3'b001,
		ST_PART = 3'b010,
		ST_RES  = 3'b011,
		ST_DESC = 3'b100
	} hdr_wst_t;
endpackage : hdr_pkg

/* hdr_rx_status.sv */
// HDLC receive descriptor status writer with AXI4-Lite registers
// Functional notes
// - Set non-octet-aligned bit 11 whenever frame bit count is not multiple of eight
// - Flag, one bit, flag is the shortest frame; closes with non-aligned set
// - Set abort bit 12 when seven or more ones arrive inside a frame
// - Runs of ones between frames never flag an abort
// - In-frame abort is reported through the normal frame received event
// - A run of ones long enough for idle also raises the idle event
// - Set CRC error bit 13 on bad CRC unless the frame aborted; CRC bytes always stored
// - Length field bits 16-31 written once, when the descriptor closes
// - Final length counts every frame octet including the CRC
// - Residual bits after the last octet add one byte to the length
// - Residual byte: valid bits at top, then a one, then zeros below
// - Residual byte always starts on a 32-bit word boundary
// - Flag, bit, flag frame gives length 1, byte x1000000 at offset zero
//
// Decided for this implementation: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/10ps
`include "hdr_defines.svh"
module hdr_rx_status
	import hdr_pkg::*;
(
	input  wire logic                 CLOCK,     // 20 MHz system clock
	input  wire logic                 RST_B,     // Sync reset, active low
	input  wire logic                 RX_DATA,   // Line data pin
	input  wire logic                 RX_STROBE, // Bit strobe pin, rising edge
	input  wire logic                 AWVALID,   // AXI write address valid
	output logic                      AWREADY,   // AXI write address ready
	input  wire logic [`HDR_AW-1:0]   AWADDR,    // AXI write address
	input  wire logic                 WVALID,    // AXI write data valid
	output logic                      WREADY,    // AXI write data ready
	input  wire logic [31:0]          WDATA,     // AXI write data
	input  wire logic [3:0]           WSTRB,     // AXI byte strobes
	output logic                      BVALID,    // AXI response valid
	input  wire logic                 BREADY,    // AXI response ready
	output logic [1:0]                BRESP,     // AXI write response
	input  wire logic                 ARVALID,   // AXI read address valid
	output logic                      ARREADY,   // AXI read address ready
	input  wire logic [`HDR_AW-1:0]   ARADDR,    // AXI read address
	output logic                      RVALID,    // AXI read data valid
	input  wire logic                 RREADY,    // AXI read data ready
	output logic [31:0]               RDATA,     // AXI read data
	output logic [1:0]                RRESP,     // AXI read response
	output logic                      MEM_REQ,   // Memory write request
	output logic [31:0]               MEM_ADDR,  // Memory word address
	output logic [31:0]               MEM_WDATA, // Memory write data
	output logic [3:0]                MEM_BE,    // Memory byte enables
	input  wire logic                 MEM_ACK,   // Memory write taken
	output logic                      IRQ        // Level interrupt
);
	logic             rxd_s1, rxd_s2, stb_s1, stb_s2, stb_s3;
	logic             bit_en;
	logic             d_valid, d_bit, flag_seen, abort_seen, idle_seen, crc_ok;
	logic [31:0]      ctrl, buf_ptr, desc_addr, desc_stat;
	logic [1:0]       ev_status, ev_mask, ev_set;
	logic             rd_clr;
	logic             en, in_frame, frame_bits, close_now;
	logic [7:0]       sh;
	logic [2:0]       res_cnt;
	logic [15:0]      byte_cnt, woff;
	logic [1:0]       wcnt;
	logic [31:0]      wbuf;
	logic             dw_valid;
	logic [31:0]      dw_data;
	logic [15:0]      dw_off;
	logic             cl_valid, cl_has_res;
	logic [31:0]      cl_part, cl_desc;
	logic [3:0]       cl_be;
	logic [15:0]      cl_part_off, cl_res_off;
	logic [7:0]       cl_res;
	logic [31:0]      base;
	hdr_wst_t         st, next_st;
	logic             next_req;
	logic [31:0]      next_addr, next_wdata;
	logic [3:0]       next_be;
	logic             dw_take, cl_done;
	logic             aw_got, w_got, wr_fire;
	logic [`HDR_AW-1:0] aw_q;
	logic [31:0]      w_q;
	logic [3:0]       s_q;
	logic [31:0]      rd_mux;
	logic             rd_ok, wr_ok;

	// Pin synchronisers
	always_ff @(posedge CLOCK) begin
		if (!RST_B) begin
			rxd_s1 <= 1'b0;
			rxd_s2 <= 1'b0;
			stb_s1 <= 1'b0;
			stb_s2 <= 1'b0;
			stb_s3 <= 1'b0;
		end else begin
			rxd_s1 <= RX_DATA;
			rxd_s2 <= rxd_s1;
			stb_s1 <= RX_STROBE;
			stb_s2 <= stb_s1;
			stb_s3 <= stb_s2;
		end
	end
	assign bit_en = stb_s2 && !stb_s3;

	hdr_bit_rx u_bit (
		.clk        (CLOCK),
		.rst_b      (RST_B),
		.bit_en     (bit_en),
		.bit_in     (rxd_s2),
		.out_valid  (d_valid),
		.out_bit    (d_bit),
		.flag_seen  (flag_seen),
		.abort_seen (abort_seen),
		.idle_seen  (idle_seen)
	);

	hdr_crc u_crc (
		.clk    (CLOCK),
		.rst_b  (RST_B),
		.init   (flag_seen || abort_seen),
		.crc32  (ctrl[`HDR_CTRL_C32]),
		.bit_en (d_valid && in_frame),
		.bit_in (d_bit),
		.crc_ok (crc_ok)
	);

	assign en         = ctrl[`HDR_CTRL_EN];
	assign frame_bits = (byte_cnt != 16'h0000) || (res_cnt != 3'h0);
	assign close_now  = en && in_frame && frame_bits && (flag_seen || abort_seen);

	// Frame assembly, octets packed little end first into words
	always_ff @(posedge CLOCK) begin
		if (!RST_B) begin
			in_frame <= 1'b0;
			sh       <= 8'h00;
			res_cnt  <= 3'h0;
			byte_cnt <= 16'h0000;
			woff     <= 16'h0000;
			wcnt     <= 2'h0;
			wbuf     <= 32'h00000000;
			dw_valid <= 1'b0;
			dw_data  <= 32'h00000000;
			dw_off   <= 16'h0000;
		end else if (!en || flag_seen || abort_seen) begin
			in_frame <= en && flag_seen;
			sh       <= 8'h00;
			res_cnt  <= 3'h0;
			byte_cnt <= 16'h0000;
			woff     <= 16'h0000;
			wcnt     <= 2'h0;
			wbuf     <= 32'h00000000;
			if (dw_take)
				dw_valid <= 1'b0;
		end else begin
			if (dw_take)
				dw_valid <= 1'b0;
			if (d_valid && in_frame) begin
				if (res_cnt == 3'h7) begin
					sh       <= 8'h00;
					res_cnt  <= 3'h0;
					byte_cnt <= byte_cnt + 16'h0001;
					if (wcnt == 2'h3) begin
						dw_valid <= 1'b1;
						dw_data  <= {d_bit, sh[7:1], wbuf[23:0]};
						dw_off   <= woff;
						woff     <= woff + 16'h0004;
						wbuf     <= 32'h00000000;
						wcnt     <= 2'h0;
					end else begin
						wbuf[{wcnt, 3'h0} +: 8] <= {d_bit, sh[7:1]};
						wcnt                    <= wcnt + 2'h1;
					end
				end else begin
					sh      <= {d_bit, sh[7:1]};
					res_cnt <= res_cnt + 3'h1;
				end
			end
		end
	end

	// Close record: partial word, residual byte, descriptor word
	always_ff @(posedge CLOCK) begin
		if (!RST_B) begin
			cl_valid    <= 1'b0;
			cl_has_res  <= 1'b0;
			cl_part     <= 32'h00000000;
			cl_be       <= 4'h0;
			cl_part_off <= 16'h0000;
			cl_res_off  <= 16'h0000;
			cl_res      <= 8'h00;
			cl_desc     <= 32'h00000000;
		end else if (close_now) begin
			cl_valid    <= 1'b1;
			cl_has_res  <= (res_cnt != 3'h0);
			cl_part     <= wbuf;
			cl_be       <= 4'((4'h1 << wcnt) - 4'h1);
			cl_part_off <= woff;
			cl_res_off  <= (wcnt != 2'h0) ? 16'(woff + 16'h0004) : woff;
			cl_res      <= sh | (8'h01 << (3'h7 - res_cnt));
			cl_desc     <= 32'h00000000;
			cl_desc[`HDR_FLD_LEN +: 16] <= 16'(byte_cnt + {15'h0000, res_cnt != 3'h0});
			cl_desc[`HDR_FLD_NO] <= (res_cnt != 3'h0);
			cl_desc[`HDR_FLD_AB] <= abort_seen;
			cl_desc[`HDR_FLD_CR] <= !abort_seen && !crc_ok;
		end else if (cl_done) begin
			cl_valid <= 1'b0;
		end
	end

	// Memory writer
	assign base    = {buf_ptr[31:2], 2'h0};
	assign dw_take = (st == ST_DATA) && MEM_ACK;
	assign cl_done = (st == ST_DESC) && MEM_ACK;

	always_comb begin
		next_st    = st;
		next_req   = MEM_REQ;
		next_addr  = MEM_ADDR;
		next_wdata = MEM_WDATA;
		next_be    = MEM_BE;
		case (st)
			ST_IDLE: begin
				if (dw_valid) begin
					next_st    = ST_DATA;
					next_req   = 1'b1;
					next_addr  = base + {16'h0000, dw_off};
					next_wdata = dw_data;
					next_be    = 4'hF;
				end else if (cl_valid && cl_be != 4'h0) begin
					next_st    = ST_PART;
					next_req   = 1'b1;
					next_addr  = base + {16'h0000, cl_part_off};
					next_wdata = cl_part;
					next_be    = cl_be;
				end else if (cl_valid && cl_has_res) begin
					next_st    = ST_RES;
					next_req   = 1'b1;
					next_addr  = base + {16'h0000, cl_res_off};
					next_wdata = {24'h000000, cl_res};
					next_be    = 4'h1;
				end else if (cl_valid) begin
					next_st    = ST_DESC;
					next_req   = 1'b1;
					next_addr  = desc_addr;
					next_wdata = cl_desc;
					next_be    = 4'hF;
				end
			end
			ST_DATA: begin
				if (MEM_ACK) begin
					next_st  = ST_IDLE;
					next_req = 1'b0;
				end
			end
			ST_PART: begin
				if (MEM_ACK && cl_has_res) begin
					next_st    = ST_RES;
					next_addr  = base + {16'h0000, cl_res_off};
					next_wdata = {24'h000000, cl_res};
					next_be    = 4'h1;
				end else if (MEM_ACK) begin
					next_st    = ST_DESC;
					next_addr  = desc_addr;
					next_wdata = cl_desc;
					next_be    = 4'hF;
				end
			end
			ST_RES: begin
				if (MEM_ACK) begin
					next_st    = ST_DESC;
					next_addr  = desc_addr;
					next_wdata = cl_desc;
					next_be    = 4'hF;
				end
			end
			ST_DESC: begin
				if (MEM_ACK) begin
					next_st  = ST_IDLE;
					next_req = 1'b0;
				end
			end
			default: begin
				next_st  = ST_IDLE;
				next_req = 1'b0;
			end
		endcase
	end

	always_ff @(posedge CLOCK) begin
		if (!RST_B) begin
			st        <= ST_IDLE;
			MEM_REQ   <= 1'b0;
			MEM_ADDR  <= 32'h00000000;
			MEM_WDATA <= 32'h00000000;
			MEM_BE    <= 4'h0;
			desc_stat <= 32'h00000000;
		end else begin
			st        <= next_st;
			MEM_REQ   <= next_req;
			MEM_ADDR  <= next_addr;
			MEM_WDATA <= next_wdata;
			MEM_BE    <= next_be;
			if (cl_done)
				desc_stat <= cl_desc;
		end
	end

	// Events: set wins over read clear
	assign ev_set = {idle_seen && en, cl_done};
	assign rd_clr = ARVALID && ARREADY && (ARADDR == `HDR_OFF_EVST);

	always_ff @(posedge CLOCK) begin
		if (!RST_B) begin
			ev_status <= 2'h0;
			IRQ       <= 1'b0;
		end else begin
			ev_status <= ev_set | (rd_clr ? 2'h0 : ev_status);
			IRQ       <= |(ev_status & ev_mask);
		end
	end

	// AXI4-Lite slave
	assign wr_fire = aw_got && w_got && !BVALID;
	assign wr_ok   = (aw_q == `HDR_OFF_CTRL) || (aw_q == `HDR_OFF_BUFPTR) ||
			(aw_q == `HDR_OFF_DESCA) || (aw_q == `HDR_OFF_DSTAT) ||
			(aw_q == `HDR_OFF_EVST) || (aw_q == `HDR_OFF_EVMASK);

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
			input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i])
				r[i*8 +: 8] = nw[i*8 +: 8];
		end
		return r;
	endfunction : merge

	always_ff @(posedge CLOCK) begin
		if (!RST_B) begin
			AWREADY <= 1'b1;
			WREADY  <= 1'b1;
			aw_got  <= 1'b0;
			w_got   <= 1'b0;
			aw_q    <= '0;
			w_q     <= 32'h00000000;
			s_q     <= 4'h0;
			BVALID  <= 1'b0;
			BRESP   <= `HDR_RESP_OK;
		end else begin
			if (AWVALID && AWREADY) begin
				aw_got  <= 1'b1;
				aw_q    <= AWADDR;
				AWREADY <= 1'b0;
			end
			if (WVALID && WREADY) begin
				w_got  <= 1'b1;
				w_q    <= WDATA;
				s_q    <= WSTRB;
				WREADY <= 1'b0;
			end
			if (wr_fire) begin
				BVALID <= 1'b1;
				BRESP  <= wr_ok ? `HDR_RESP_OK : `HDR_RESP_ERR;
			end
			if (BVALID && BREADY) begin
				BVALID  <= 1'b0;
				aw_got  <= 1'b0;
				w_got   <= 1'b0;
				AWREADY <= 1'b1;
				WREADY  <= 1'b1;
			end
		end
	end

	always_ff @(posedge CLOCK) begin
		if (!RST_B) begin
			ctrl      <= `HDR_CTRL_RST;
			buf_ptr   <= `HDR_PTR_RST;
			desc_addr <= `HDR_PTR_RST;
			ev_mask   <= `HDR_MASK_RST;
		end else if (wr_fire) begin
			case (aw_q)
				`HDR_OFF_CTRL:   ctrl      <= merge(ctrl, w_q, s_q);
				`HDR_OFF_BUFPTR: buf_ptr   <= merge(buf_ptr, w_q, s_q);
				`HDR_OFF_DESCA:  desc_addr <= merge(desc_addr, w_q, s_q);
				`HDR_OFF_EVMASK: ev_mask   <= s_q[0] ? w_q[1:0] : ev_mask;
				default: begin
				end
			endcase
		end
	end

	always_comb begin
		rd_ok  = 1'b1;
		rd_mux = 32'h00000000;
		case (ARADDR)
			`HDR_OFF_CTRL:   rd_mux = ctrl;
			`HDR_OFF_BUFPTR: rd_mux = buf_ptr;
			`HDR_OFF_DESCA:  rd_mux = desc_addr;
			`HDR_OFF_DSTAT:  rd_mux = desc_stat;
			`HDR_OFF_EVST:   rd_mux = {30'h00000000, ev_status};
			`HDR_OFF_EVMASK: rd_mux = {30'h00000000, ev_mask};
			default:         rd_ok  = 1'b0;
		endcase
	end

	always_ff @(posedge CLOCK) begin
		if (!RST_B) begin
			ARREADY <= 1'b1;
			RVALID  <= 1'b0;
			RDATA   <= 32'h00000000;
			RRESP   <= `HDR_RESP_OK;
		end else if (ARVALID && ARREADY) begin
			ARREADY <= 1'b0;
			RVALID  <= 1'b1;
			RDATA   <= rd_mux;
			RRESP   <= rd_ok ? `HDR_RESP_OK : `HDR_RESP_ERR;
		end else if (RVALID && RREADY) begin
			RVALID  <= 1'b0;
			ARREADY <= 1'b1;
		end
	end

	// Checks
	default clocking cb @(posedge CLOCK); endclocking
	default disable iff (!RST_B);

	a_nonalign_flag: assert property (close_now && res_cnt != 3'h0 |=> cl_desc[`HDR_FLD_NO])
		else $error("non-aligned frame closed without its flag");
	a_min_frame: assert property (close_now && byte_cnt == 16'h0000 && res_cnt == 3'h1
		|=> cl_desc[31:16] == 16'h0001 && cl_res[6:0] == 7'h40 && cl_res_off == 16'h0000
		&& cl_desc[`HDR_FLD_NO])
		else $error("shortest frame reported wrongly");
	a_abort_flag: assert property (close_now && abort_seen |=> cl_desc[`HDR_FLD_AB])
		else $error("in-frame abort not flagged");
	a_gap_abort: assert property (abort_seen && !frame_bits |=> !$rose(cl_valid))
		else $error("abort between frames closed a descriptor");
	a_abort_event: assert property (cl_done && cl_desc[`HDR_FLD_AB] |=> ev_status[`HDR_EV_RXF])
		else $error("aborted frame gave no frame event");
	a_idle_event: assert property (idle_seen && en |=> ev_status[`HDR_EV_IDLE] ##1 IRQ || !ev_mask[1])
		else $error("idle run not reported");
	a_crc_flag: assert property (close_now && !abort_seen && !crc_ok |=> cl_desc[`HDR_FLD_CR])
		else $error("bad CRC not flagged");
	a_len_field: assert property (close_now |=> cl_desc[31:16] ==
		16'($past(byte_cnt) + {15'h0000, $past(res_cnt) != 3'h0}))
		else $error("length field wrong");
	a_desc_word: assert property (st == ST_DESC && MEM_REQ |-> MEM_WDATA == cl_desc
		&& MEM_ADDR == desc_addr && MEM_BE == 4'hF)
		else $error("descriptor word not written whole");
	a_res_align: assert property (st == ST_RES && MEM_REQ |-> MEM_ADDR[1:0] == 2'h0
		&& MEM_BE == 4'h1 && MEM_WDATA[7:0] == cl_res)
		else $error("residual byte off a word boundary");
	a_event_after: assert property ($rose(ev_status[`HDR_EV_RXF]) |-> $past(cl_done))
		else $error("frame event without descriptor write");

	c_abort_close: cover property (close_now && abort_seen);
	c_min_frame: cover property (close_now && byte_cnt == 16'h0000 && res_cnt == 3'h1);
	c_res_write: cover property (st == ST_RES && MEM_ACK);
	c_idle: cover property (idle_seen && en);
endmodule : hdr_rx_status

/* tb.sv */
// Self-checking bench for the receive status block
`timescale 1ns/10ps
`include "hdr_defines.svh"
module tb;
	typedef struct {int n; logic [6:0] pat; logic [7:0] res; logic [31:0] dm;} hdr_row_t;
	logic        CLOCK = 0, RST_B = 0, RX_DATA = 0, RX_STROBE = 0;
	logic        AWVALID = 0, WVALID = 0, BREADY = 0, ARVALID = 0, RREADY = 0;
	logic [7:0]  AWADDR = 0, ARADDR = 0;
	logic [31:0] WDATA = 0;
	logic [3:0]  WSTRB = 0;
	logic        AWREADY, WREADY, BVALID, ARREADY, RVALID, MEM_REQ, MEM_ACK, IRQ;
	logic [1:0]  BRESP, RRESP;
	logic [31:0] RDATA, MEM_ADDR, MEM_WDATA;
	logic [3:0]  MEM_BE;
	int          errors = 0;
	int          n_checks = 0;
	hdr_row_t    rows [4] = '{'{1, 7'h01, 8'hC0, 32'hFFFFFFFF}, '{1, 7'h00, 8'h40, 32'hFFFFFFFF},
		'{3, 7'h05, 8'hB0, 32'hFFFFDFFF}, '{7, 7'h1B, 8'h37, 32'hFFFFDFFF}};

	always #25 CLOCK = ~CLOCK;

	hdr_rx_status dut_u (.CLOCK, .RST_B, .RX_DATA, .RX_STROBE, .AWVALID, .AWREADY, .AWADDR,
		.WVALID, .WREADY, .WDATA, .WSTRB, .BVALID, .BREADY, .BRESP, .ARVALID, .ARREADY,
		.ARADDR, .RVALID, .RREADY, .RDATA, .RRESP, .MEM_REQ, .MEM_ADDR, .MEM_WDATA, .MEM_BE,
		.MEM_ACK, .IRQ);
	hdr_mem_model mem_u (.clk(CLOCK), .rst_b(RST_B), .req(MEM_REQ), .addr(MEM_ADDR),
		.wdata(MEM_WDATA), .be(MEM_BE), .ack(MEM_ACK));

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_checks++;
		if (g !== e) begin
			errors++;
			$display("[ERR] %s exp %h got %h", nm, e, g);
		end
	endtask : chk

	task automatic end_sim;
		if (errors == 0 && n_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : end_sim

	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		logic aw, w;
		@(posedge CLOCK);
		aw = 1;
		w = 1;
		AWADDR <= a;
		WDATA <= d;
		WSTRB <= 4'hF;
		AWVALID <= 1'b1;
		WVALID <= 1'b1;
		BREADY <= 1'b1;
		while (aw || w) begin
			@(posedge CLOCK);
			if (aw && AWREADY === 1'b1) begin
				aw = 0;
				AWVALID <= 1'b0;
			end
			if (w && WREADY === 1'b1) begin
				w = 0;
				WVALID <= 1'b0;
			end
		end
		while (BVALID !== 1'b1) @(posedge CLOCK);
		BREADY <= 1'b0;
		chk("bresp", 32'(er), 32'(BRESP));
	endtask : axi_wr

	task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge CLOCK);
		ARADDR <= a;
		ARVALID <= 1'b1;
		RREADY <= 1'b1;
		do @(posedge CLOCK); while (ARREADY !== 1'b1);
		ARVALID <= 1'b0;
		while (RVALID !== 1'b1) @(posedge CLOCK);
		d = RDATA;
		r = RRESP;
		RREADY <= 1'b0;
	endtask : axi_rd

	task automatic send_bit(input logic b);
		RX_DATA <= b;
		repeat (2) @(posedge CLOCK);
		RX_STROBE <= 1'b1;
		repeat (3) @(posedge CLOCK);
		RX_STROBE <= 1'b0;
		repeat (2) @(posedge CLOCK);
	endtask : send_bit

	task automatic flag_b;
		for (int i = 0; i < 8; i++) send_bit(i != 0 && i != 7);
	endtask : flag_b

	task automatic ones(input int k);
		for (int i = 0; i < k; i++) send_bit(1'b1);
	endtask : ones

	task automatic wait_irq;
		for (int i = 0; i < 400 && IRQ !== 1'b1; i++) @(posedge CLOCK);
	endtask : wait_irq

	initial begin
		repeat (20000) @(posedge CLOCK);
		errors++;
		end_sim();
	end

	initial begin
		logic [31:0] d;
		logic [1:0]  r;
		int          n0;
		repeat (3) @(posedge CLOCK);
		RST_B <= 1'b1;
		chk("rst_out", 32'h8, {28'h0, AWREADY, BVALID, MEM_REQ, IRQ});
		axi_rd(`HDR_OFF_CTRL, d, r);
		chk("ctrl_rst", `HDR_CTRL_RST, d);
		axi_rd(`HDR_OFF_EVMASK, d, r);
		chk("mask_rst", 32'h0, d);
		axi_rd(8'h18, d, r);
		chk("unm_rd", 32'h2, d | 32'(r));
		axi_wr(8'h18, 32'hFFFFFFFF, `HDR_RESP_ERR);
		axi_wr(`HDR_OFF_CTRL, 32'h1, `HDR_RESP_OK);
		axi_wr(`HDR_OFF_BUFPTR, 32'h100, `HDR_RESP_OK);
		axi_wr(`HDR_OFF_DESCA, 32'h200, `HDR_RESP_OK);
		axi_wr(`HDR_OFF_EVMASK, 32'h1, `HDR_RESP_OK);
		foreach (rows[k]) begin
			axi_wr(`HDR_OFF_CTRL, 32'h1 | 32'((k % 2) * 2), `HDR_RESP_OK);
			n0 = mem_u.n;
			flag_b();
			for (int i = 0; i < rows[k].n; i++) send_bit(rows[k].pat[i]);
			flag_b();
			flag_b();
			wait_irq();
			chk("irq", 32'h1, 32'(IRQ));
			chk("n_wr", 32'(n0 + 2), 32'(mem_u.n));
			chk("res_addr", 32'h100, mem_u.wa[mem_u.n - 2]);
			chk("res_be", 32'h1, 32'(mem_u.wb[mem_u.n - 2]));
			chk("res_byte", 32'(rows[k].res), mem_u.wd[mem_u.n - 2] & 32'hFF);
			chk("desc_addr", 32'h200, mem_u.wa[mem_u.n - 1]);
			chk("desc", 32'h12800 & rows[k].dm, mem_u.wd[mem_u.n - 1] & rows[k].dm);
			axi_rd(`HDR_OFF_DSTAT, d, r);
			chk("dstat", mem_u.wd[mem_u.n - 1], d);
			axi_rd(`HDR_OFF_EVST, d, r);
			chk("ev_rxf", 32'h1, d);
			repeat (2) @(posedge CLOCK);
			chk("irq_clr", 32'h0, 32'(IRQ));
		end
		n0 = mem_u.n;
		ones(16);
		flag_b();
		axi_rd(`HDR_OFF_EVST, d, r);
		chk("ev_idle", 32'h2, d);
		chk("irq_mask", 32'h0, 32'(IRQ));
		chk("n_idle", 32'(n0), 32'(mem_u.n));
		for (int i = 0; i < 12; i++) send_bit(i[0]);
		ones(8);
		flag_b();
		flag_b();
		wait_irq();
		chk("abort", 32'h1000, mem_u.wd[mem_u.n - 1] & 32'h3000);
		axi_rd(`HDR_OFF_EVST, d, r);
		chk("ev_abort", 32'h1, d);
		flag_b();
		for (int i = 0; i < 32; i++) send_bit(1'b0);
		flag_b();
		flag_b();
		wait_irq();
		chk("good_crc", 32'h00040000, mem_u.wd[mem_u.n - 1]);
		chk("crc_word", 32'h0, mem_u.wd[mem_u.n - 2]);
		chk("crc_addr", 32'h100, mem_u.wa[mem_u.n - 2]);
		end_sim();
	end
endmodule : tb
